// *** core/njd_node_diag.sv ***
/*
 Device end: start-up gating, duplicate station detection, probing and
 sticky diagnostic flags of a token-passing node, reached over the host
 port. Assumes token, answer, NAK and timer events arrive as one-cycle
 pulses from logic on the same clock; the receive line is asynchronous.
*/
// Overview of operation
// - Zero station number keeps core idle; line activity and transmitter free flags still set
// - Non-zero number wakes core; join needs enable
// - Config bit 5 enables transmit and joining
// - Twin flag within 420mS, or 840mS
// - Compare station with token destination, watch answers
// - Diagnostic read clears twin address flag
// - Own timer expiry reconfigures, sets self flag
// - Diagnostic read clears self reconfiguration flag
// - Joining causes reconfiguration and sets self flag
// - Watch answers to tokens for probe station
// - Probe answered by other node sets flag
// - Receive line high sets line activity flag
// - Foreign token seen sets token observed flag
// - Threshold NAKs set refusal flag and interrupt
// - Short select bit picks 4, else 128
// - Refusal counter wraps; clear, then sets again
// - After disable, next token sets transmitter free
// - Next node change sets its own flag
// - Odd address write and read fix bus
// - Host writes options before station number
// - Host keeps transmit off until number unique
// - Host disables transmitter on repeated self reconfigs
// - Station write stores D1H and number to RAM
`include "njd_params.svh"
`default_nettype none
module njd_node_diag #(
	parameter int TWIN_CYC = `NJD_TWIN_MS * `NJD_CLK_KHZ,
	parameter int TWIN_LONG_CYC = `NJD_TWIN_LONG_MS * `NJD_CLK_KHZ
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	njd_hbus_if.dev bus,
	input wire logic i_rx_line,
	input wire logic i_tok_seen,
	input wire logic [7:0] i_tok_did,
	input wire logic i_tok_own,
	input wire logic i_tok_answered,
	input wire logic i_tok_to_me,
	input wire logic i_trt_expired,
	input wire logic i_nak,
	input wire logic i_tx_start,
	input wire logic [7:0] i_next_id,
	output logic o_core_run,
	output logic o_pass_tokens,
	output logic o_network_reconfig_event_req,
	output logic o_refusal_irq,
	output logic o_tx_free,
	output logic o_ram_we,
	output logic [10:0] o_ram_addr,
	output logic [7:0] o_ram_data
);
	function automatic logic sticky(input logic set, input logic clr,
		input logic q);
		return set | (q & ~clr);
	endfunction

	function automatic logic wraps(input logic [6:0] c, input logic short);
		logic [6:0] n;
		n = c + 7'h01;
		return short ? ((n & `NJD_SHORT_MASK) == 7'h00) : (n == 7'h00);
	endfunction

	logic [7:0] station_r, probe_r, opts_r, cfg_r, next_id_r, did_r, rdata_r;
	logic twin_r, selfrc_r, act_r, tok_r, pmatch_r, refl_r, nxtchg_r;
	logic txfree_r, abort_r, pend_r, joined_r, oddw_r, bus_known_r;
	logic [6:0] nak_cnt_r;
	logic [`NJD_WIN_W-1:0] win_r;
	logic run_r, pass_r, network_reconfig_event_r, ram_we_r;
	logic [10:0] ram_addr_r;
	logic [7:0] ram_data_r;
	njd_pkg::njd_ram_type ram_st_r, ram_st_nxt;
	logic rx_s;
	logic [7:0] diag_val, misc_val, rd_val;

	njd_sync2 u_rx_sync (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_async(i_rx_line),
		.o_sync(rx_s)
	);

	//****************************************************
	// Host port decode
	//****************************************************
	wire logic wr = bus.cs & bus.we;
	wire logic rd = bus.cs & bus.rd;
	wire logic wr_cmd = wr & (bus.addr == `NJD_A_CMD);
	wire logic wr_cfg = wr & (bus.addr == `NJD_A_CFG);
	wire logic wr_sta = wr & (bus.addr == `NJD_A_STA);
	wire logic wr_probe = wr & (bus.addr == `NJD_A_PROBE);
	wire logic wr_opts = wr & (bus.addr == `NJD_A_OPTS);
	wire logic rd_diag = rd & (bus.addr == `NJD_A_DIAG);
	wire logic clr_cmd = wr_cmd & bus.wdata[`NJD_CMD_CLR];
	wire logic dis_cmd = wr_cmd & bus.wdata[`NJD_CMD_DIS];
	wire logic odd_wr = wr & bus.addr[0];
	wire logic odd_rd = rd & bus.addr[0];

	//****************************************************
	// Core state and events
	//****************************************************
	wire logic srst = cfg_r[`NJD_CFG_SRST];
	wire logic run = (station_r != 8'h00) & ~srst;
	wire logic joined = run & cfg_r[`NJD_CFG_JOIN];
	wire logic tok_ext = run & i_tok_seen & ~i_tok_own;
	wire logic ans = run & i_tok_answered & pend_r;
	wire logic twin_set = ans & ~joined & (did_r == station_r);
	wire logic pm_set = ans & (did_r == probe_r) & (probe_r != 8'h00)
		& (probe_r != station_r);
	wire logic network_reconfig_event_go = joined & (~joined_r | i_trt_expired);
	wire logic nak_lim = run & i_nak
		& wraps(nak_cnt_r, opts_r[`NJD_OPT_SHORT]);
	wire logic rd_clr = rd_diag | srst;
	wire logic nxt_set = run & (i_next_id != next_id_r);
	wire logic win_fast = opts_r[`NJD_OPT_TSA] & opts_r[`NJD_OPT_TSB];
	wire logic [`NJD_WIN_W-1:0] win_load = win_fast
		? `NJD_WIN_W'(TWIN_CYC) : `NJD_WIN_W'(TWIN_LONG_CYC);

	//****************************************************
	// Read data
	//****************************************************
	assign diag_val[`NJD_D_TWIN] = twin_r;
	assign diag_val[`NJD_D_SELF] = selfrc_r;
	assign diag_val[`NJD_D_ACT] = act_r;
	assign diag_val[`NJD_D_TOK] = tok_r;
	assign diag_val[`NJD_D_PROBE] = pmatch_r;
	assign diag_val[`NJD_D_REFUSE] = refl_r;
	assign diag_val[`NJD_D_NEXT] = nxtchg_r;
	assign diag_val[`NJD_D_TXFREE] = txfree_r;
	assign misc_val = {6'h00, win_r != `NJD_WIN_W'(0), bus_known_r};
	assign rd_val = (bus.addr == `NJD_A_DIAG) ? diag_val
		: (bus.addr == `NJD_A_CFG) ? cfg_r
		: (bus.addr == `NJD_A_STA) ? station_r
		: (bus.addr == `NJD_A_PROBE) ? probe_r
		: (bus.addr == `NJD_A_OPTS) ? opts_r
		: (bus.addr == `NJD_A_NEXT) ? next_id_r
		: (bus.addr == `NJD_A_MISC) ? misc_val : 8'h00;

	//****************************************************
	// Registers written by the host
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			station_r <= 8'h00;
			probe_r <= 8'h00;
			opts_r <= 8'h00;
			cfg_r <= 8'h00;
			rdata_r <= 8'h00;
		end else if (i_ce) begin
			if (wr_sta) station_r <= bus.wdata;
			if (wr_probe) probe_r <= bus.wdata;
			if (wr_opts) opts_r <= bus.wdata;
			if (wr_cfg) cfg_r <= bus.wdata;
			if (rd) rdata_r <= rd_val;
		end
	end
	assign bus.rdata = rdata_r;

	//****************************************************
	// Sticky diagnostic flags, set wins over clear
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			twin_r <= 1'b0;
			selfrc_r <= 1'b0;
			act_r <= 1'b0;
			tok_r <= 1'b0;
			pmatch_r <= 1'b0;
			nxtchg_r <= 1'b0;
			refl_r <= 1'b0;
		end else if (i_ce) begin
			twin_r <= sticky(twin_set, rd_clr, twin_r);
			selfrc_r <= sticky(network_reconfig_event_go, rd_clr, selfrc_r);
			act_r <= sticky(rx_s, rd_clr, act_r);
			tok_r <= sticky(tok_ext, rd_clr, tok_r);
			pmatch_r <= sticky(pm_set, rd_clr, pmatch_r);
			nxtchg_r <= sticky(nxt_set, rd_clr, nxtchg_r);
			refl_r <= sticky(nak_lim, clr_cmd | srst, refl_r);
		end
	end

	//****************************************************
	// Token tracking, refusal count and transmitter state
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			did_r <= 8'h00;
			pend_r <= 1'b0;
			nak_cnt_r <= 7'h00;
			next_id_r <= 8'h00;
			joined_r <= 1'b0;
			abort_r <= 1'b0;
			txfree_r <= 1'b0;
		end else if (i_ce) begin
			if (tok_ext) did_r <= i_tok_did;
			pend_r <= tok_ext | (pend_r & ~i_tok_answered & run);
			if (run & i_nak) nak_cnt_r <= nak_cnt_r + 7'h01;
			next_id_r <= i_next_id;
			joined_r <= joined;
			abort_r <= dis_cmd | (abort_r & ~i_tok_to_me);
			if (abort_r & i_tok_to_me) txfree_r <= 1'b1;
			else if (i_tx_start) txfree_r <= 1'b0;
		end
	end

	//****************************************************
	// Twin check window and bus determination
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			win_r <= `NJD_WIN_W'(0);
			oddw_r <= 1'b0;
			bus_known_r <= 1'b0;
		end else if (i_ce) begin
			if (wr_sta & (bus.wdata != 8'h00)) win_r <= win_load;
			else if (win_r != `NJD_WIN_W'(0)) win_r <= win_r - 1'b1;
			if (odd_wr) oddw_r <= 1'b1;
			if (odd_rd & oddw_r) bus_known_r <= 1'b1;
		end
	end

	//****************************************************
	// Buffer RAM marker after a station number write
	//****************************************************
	always_comb begin
		case (ram_st_r)
			njd_pkg::NJD_RIDLE: ram_st_nxt = wr_sta ? njd_pkg::NJD_RWR0
				: njd_pkg::NJD_RIDLE;
			njd_pkg::NJD_RWR0: ram_st_nxt = njd_pkg::NJD_RWR1;
			njd_pkg::NJD_RWR1: ram_st_nxt = njd_pkg::NJD_RIDLE;
			default: ram_st_nxt = njd_pkg::NJD_RIDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ram_st_r <= njd_pkg::NJD_RIDLE;
			ram_we_r <= 1'b0;
			ram_addr_r <= `NJD_RAM_A0;
			ram_data_r <= 8'h00;
		end else if (i_ce) begin
			ram_st_r <= ram_st_nxt;
			ram_we_r <= ram_st_r != njd_pkg::NJD_RIDLE;
			ram_addr_r <= (ram_st_r == njd_pkg::NJD_RWR1)
				? `NJD_RAM_A1 : `NJD_RAM_A0;
			ram_data_r <= (ram_st_r == njd_pkg::NJD_RWR1)
				? station_r : `NJD_RAM_MARK;
		end
	end

	//****************************************************
	// Core outputs
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			run_r <= 1'b0;
			pass_r <= 1'b0;
			network_reconfig_event_r <= 1'b0;
		end else if (i_ce) begin
			run_r <= run;
			pass_r <= joined;
			network_reconfig_event_r <= network_reconfig_event_go;
		end
	end

	assign o_core_run = run_r;
	assign o_pass_tokens = pass_r;
	assign o_network_reconfig_event_req = network_reconfig_event_r;
	assign o_refusal_irq = refl_r;
	assign o_tx_free = txfree_r;
	assign o_ram_we = ram_we_r;
	assign o_ram_addr = ram_addr_r;
	assign o_ram_data = ram_data_r;
endmodule
`default_nettype wire

// *** pkg/njd_params.svh ***
/*
 Constants of the node join and diagnostics pair: register map of the
 device host port, field positions, command codes, timing figures and
 the controller's own APB map. Assumes inclusion by bare name.
*/
`ifndef NJD_PARAMS_SVH
`define NJD_PARAMS_SVH
`define NJD_CLK_KHZ 25000
`define NJD_TWIN_MS 420
`define NJD_TWIN_LONG_MS 840
`define NJD_POLL_MS 10
`define NJD_WIN_W 25
`define NJD_CNT_W 24
`define NJD_A_DIAG 3'h0
`define NJD_A_CMD 3'h1
`define NJD_A_CFG 3'h2
`define NJD_A_STA 3'h3
`define NJD_A_PROBE 3'h4
`define NJD_A_OPTS 3'h5
`define NJD_A_NEXT 3'h6
`define NJD_A_MISC 3'h7
`define NJD_D_TWIN 0
`define NJD_D_SELF 1
`define NJD_D_ACT 2
`define NJD_D_TOK 3
`define NJD_D_PROBE 4
`define NJD_D_REFUSE 5
`define NJD_D_NEXT 6
`define NJD_D_TXFREE 7
`define NJD_M_BUS 0
`define NJD_M_IDBUSY 1
`define NJD_CFG_JOIN 5
`define NJD_CFG_SRST 7
`define NJD_OPT_SHORT 0
`define NJD_OPT_TSA 1
`define NJD_OPT_TSB 2
`define NJD_CMD_CLR 0
`define NJD_CMD_DIS 1
`define NJD_RAM_MARK 8'hd1
`define NJD_RAM_A0 11'h000
`define NJD_RAM_A1 11'h001
`define NJD_SHORT_MASK 7'h03
`define NJD_P_CTRL 12'h000
`define NJD_P_STAT 12'h004
`define NJD_C_START 0
`define NJD_C_OPT 15:8
`define NJD_C_STA 23:16
`define NJD_S_BUSY 0
`define NJD_S_JOIN 1
`define NJD_S_FAULT 2
`define NJD_S_STA 15:8
`define NJD_S_DIAG 23:16
`endif

// *** pkg/njd_pkg.sv ***
/*
 Types of the node join and diagnostics pair.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package njd_pkg;
	typedef enum logic [2:0] {
		NJD_RIDLE = 3'h1,
		NJD_RWR0 = 3'h2,
		NJD_RWR1 = 3'h4
	} njd_ram_type;
	typedef enum logic [9:0] {
		NJD_HIDLE = 10'h001,
		NJD_HDMYW = 10'h002,
		NJD_HDMYR = 10'h004,
		NJD_HOPTW = 10'h008,
		NJD_HNIDW = 10'h010,
		NJD_HWAIT = 10'h020,
		NJD_HDRD = 10'h040,
		NJD_HDCAP = 10'h080,
		NJD_HJOINW = 10'h100,
		NJD_HDISW = 10'h200
	} njd_host_type;
endpackage
`default_nettype wire

// *** pkg/njd_hbus_if.sv ***
/*
 Host port between controller and device: one strobe cycle per access,
 read data valid in the cycle after the read strobe.
 Assumes both ends run on the same clock.
*/
`default_nettype none
interface njd_hbus_if;
	logic cs;
	logic we;
	logic rd;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev(input cs, input we, input rd, input addr, input wdata,
		output rdata);
	modport host(output cs, output we, output rd, output addr,
		output wdata, input rdata);
endinterface
`default_nettype wire

// *** core/njd_sync2.sv ***
/*
 Two flip-flop synchroniser for one level from outside the clock domain.
 Assumes a single clock and a clock enable shared with its user.
*/
`default_nettype none
module njd_sync2 (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_r;
	logic sync_r;
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else if (i_ce) begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end
	assign o_sync = sync_r;
endmodule
`default_nettype wire

// *** core/njd_host_init.sv ***
/*
 Controller end: APB slave taking a start order, then brings the node
 up over the host port: bus determination, options, station number,
 uniqueness check, join, and fault watch. Assumes the device answers a
 read in the cycle after the read strobe and shares the clock.
*/
`include "njd_params.svh"
`default_nettype none
module njd_host_init #(
	parameter int WAIT_CYC = `NJD_TWIN_MS * `NJD_CLK_KHZ,
	parameter int POLL_CYC = `NJD_POLL_MS * `NJD_CLK_KHZ
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_busy,
	output logic o_joined,
	njd_hbus_if.host bus
);
	njd_pkg::njd_host_type st_r, st_nxt;
	logic [7:0] opt_r, sta_r, diag_r;
	logic [`NJD_CNT_W-1:0] cnt_r;
	logic joined_r, fault_r, last_rc_r, busy_r;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r, stat_val;
	logic cs_r, we_r, rd_r;
	logic [2:0] addr_r;
	logic [7:0] wdata_r;

	//****************************************************
	// APB decode
	//****************************************************
	wire logic setup = i_psel & ~i_penable;
	wire logic acc = i_psel & i_penable & pready_r;
	wire logic is_ctrl = i_paddr == `NJD_P_CTRL;
	wire logic is_stat = i_paddr == `NJD_P_STAT;
	wire logic go = acc & i_pwrite & is_ctrl & i_pwdata[`NJD_C_START]
		& (st_r == njd_pkg::NJD_HIDLE);
	wire logic twin = bus.rdata[`NJD_D_TWIN];
	wire logic rc = bus.rdata[`NJD_D_SELF];
	wire logic cap = st_r == njd_pkg::NJD_HDCAP;
	wire logic bump = cap & ~joined_r & twin;
	wire logic [7:0] sta_try = go ? i_pwdata[`NJD_C_STA] : sta_r + 8'h01;
	wire logic [7:0] sta_nxt = (go | bump)
		? ((sta_try == 8'h00) ? 8'h01 : sta_try) : sta_r;

	assign stat_val[`NJD_S_BUSY] = busy_r;
	assign stat_val[`NJD_S_JOIN] = joined_r;
	assign stat_val[`NJD_S_FAULT] = fault_r;
	assign stat_val[7:3] = 5'h00;
	assign stat_val[`NJD_S_STA] = sta_r;
	assign stat_val[`NJD_S_DIAG] = diag_r;
	assign stat_val[31:24] = 8'h00;

	//****************************************************
	// Bring-up sequence
	//****************************************************
	always_comb begin
		case (st_r)
			njd_pkg::NJD_HIDLE: st_nxt = go ? njd_pkg::NJD_HDMYW
				: njd_pkg::NJD_HIDLE;
			njd_pkg::NJD_HDMYW: st_nxt = njd_pkg::NJD_HDMYR;
			njd_pkg::NJD_HDMYR: st_nxt = njd_pkg::NJD_HOPTW;
			njd_pkg::NJD_HOPTW: st_nxt = njd_pkg::NJD_HNIDW;
			njd_pkg::NJD_HNIDW: st_nxt = njd_pkg::NJD_HWAIT;
			njd_pkg::NJD_HWAIT: st_nxt = (cnt_r == `NJD_CNT_W'(0))
				? njd_pkg::NJD_HDRD : njd_pkg::NJD_HWAIT;
			njd_pkg::NJD_HDRD: st_nxt = njd_pkg::NJD_HDCAP;
			njd_pkg::NJD_HDCAP: begin
				if (!joined_r)
					st_nxt = twin ? njd_pkg::NJD_HNIDW
						: njd_pkg::NJD_HJOINW;
				else
					st_nxt = (rc & last_rc_r) ? njd_pkg::NJD_HDISW
						: njd_pkg::NJD_HWAIT;
			end
			njd_pkg::NJD_HJOINW: st_nxt = njd_pkg::NJD_HWAIT;
			njd_pkg::NJD_HDISW: st_nxt = njd_pkg::NJD_HIDLE;
			default: st_nxt = njd_pkg::NJD_HIDLE;
		endcase
	end

	//****************************************************
	// Host port strobes, one cycle per state
	//****************************************************
	wire logic n_we = (st_nxt == njd_pkg::NJD_HDMYW)
		| (st_nxt == njd_pkg::NJD_HOPTW) | (st_nxt == njd_pkg::NJD_HNIDW)
		| (st_nxt == njd_pkg::NJD_HJOINW) | (st_nxt == njd_pkg::NJD_HDISW);
	wire logic n_rd = (st_nxt == njd_pkg::NJD_HDMYR)
		| (st_nxt == njd_pkg::NJD_HDRD);
	wire logic [2:0] n_addr = (st_nxt == njd_pkg::NJD_HDMYW) ? `NJD_A_CMD
		: (st_nxt == njd_pkg::NJD_HDMYR) ? `NJD_A_MISC
		: (st_nxt == njd_pkg::NJD_HOPTW) ? `NJD_A_OPTS
		: (st_nxt == njd_pkg::NJD_HNIDW) ? `NJD_A_STA
		: (st_nxt == njd_pkg::NJD_HDRD) ? `NJD_A_DIAG : `NJD_A_CFG;
	wire logic [7:0] n_data = (st_nxt == njd_pkg::NJD_HOPTW) ? opt_r
		: (st_nxt == njd_pkg::NJD_HNIDW) ? sta_nxt
		: (st_nxt == njd_pkg::NJD_HJOINW) ? 8'h01 << `NJD_CFG_JOIN
		: 8'h00;

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			cs_r <= 1'b0;
			we_r <= 1'b0;
			rd_r <= 1'b0;
			addr_r <= 3'h0;
			wdata_r <= 8'h00;
		end else if (i_ce) begin
			cs_r <= n_we | n_rd;
			we_r <= n_we;
			rd_r <= n_rd;
			addr_r <= n_addr;
			wdata_r <= n_data;
		end
	end
	assign bus.cs = cs_r;
	assign bus.we = we_r;
	assign bus.rd = rd_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;

	//****************************************************
	// Sequence state
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			st_r <= njd_pkg::NJD_HIDLE;
			opt_r <= 8'h00;
			sta_r <= 8'h00;
			diag_r <= 8'h00;
			cnt_r <= `NJD_CNT_W'(0);
			joined_r <= 1'b0;
			fault_r <= 1'b0;
			last_rc_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (i_ce) begin
			st_r <= st_nxt;
			busy_r <= st_nxt != njd_pkg::NJD_HIDLE;
			if (go) opt_r <= i_pwdata[`NJD_C_OPT];
			sta_r <= sta_nxt;
			if (cap) diag_r <= bus.rdata;
			if (cap & joined_r) last_rc_r <= rc;
			else if (go) last_rc_r <= 1'b0;
			if (st_r != njd_pkg::NJD_HWAIT)
				cnt_r <= joined_r | (st_r == njd_pkg::NJD_HJOINW)
					? `NJD_CNT_W'(POLL_CYC) : `NJD_CNT_W'(WAIT_CYC);
			else if (cnt_r != `NJD_CNT_W'(0))
				cnt_r <= cnt_r - 1'b1;
			if (st_r == njd_pkg::NJD_HJOINW) joined_r <= 1'b1;
			else if (go | (st_r == njd_pkg::NJD_HDISW)) joined_r <= 1'b0;
			if (st_r == njd_pkg::NJD_HDISW) fault_r <= 1'b1;
			else if (go) fault_r <= 1'b0;
		end
	end

	//****************************************************
	// APB answer, no wait states
	//****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else if (i_ce) begin
			pready_r <= setup;
			pslverr_r <= setup & ~(is_ctrl | is_stat);
			prdata_r <= (setup & ~i_pwrite & is_stat) ? stat_val : 32'h0;
		end
	end

	assign o_prdata = prdata_r;
	assign o_pready = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_busy = busy_r;
	assign o_joined = joined_r;
endmodule
`default_nettype wire

// *** tb/njd_pair_chk.sv ***
/*
 Checker of the node pair: host port and device start-up outputs.
 Assumes one clock and a synchronous active-low reset.
*/
`include "njd_params.svh"
`default_nettype none
module njd_pair_chk (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic cs,
	input wire logic we,
	input wire logic rd,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic o_core_run,
	input wire logic o_pass_tokens,
	input wire logic o_network_reconfig_event_req,
	input wire logic o_ram_we,
	input wire logic [10:0] o_ram_addr,
	input wire logic [7:0] o_ram_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	logic opt_r;
	logic chk_r;
	wire logic wr = cs && we;
	wire logic cfg_wr = wr && addr == `NJD_A_CFG;
	wire logic sta_wr = wr && addr == `NJD_A_STA && wdata != 8'h00;
	wire logic dia_rd = cs && rd && addr == `NJD_A_DIAG;
	// Options seen, and a diag read since the last station write
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			opt_r <= 1'b0;
			chk_r <= 1'b0;
		end else begin
			opt_r <= opt_r || (wr && addr == `NJD_A_OPTS);
			chk_r <= (chk_r && !sta_wr) || dia_rd;
		end
	end
	// ************
	// Properties
	// ************
	sequence s_mark;
		o_ram_we && o_ram_addr == `NJD_RAM_A0 && o_ram_data == `NJD_RAM_MARK;
	endsequence
	sequence s_num;
		o_ram_we && o_ram_addr == `NJD_RAM_A1 && o_ram_data == $past(wdata, 3);
	endsequence
	property p_ram;
		sta_wr |-> ##2 s_mark ##1 s_num;
	endproperty
	property p_idle;
		!o_core_run |-> !o_pass_tokens && !o_network_reconfig_event_req;
	endproperty
	property p_wake;
		sta_wr |-> ##2 o_core_run && !o_pass_tokens;
	endproperty
	property p_join;
		cfg_wr && wdata[`NJD_CFG_JOIN] && !wdata[`NJD_CFG_SRST]
			&& o_core_run |-> ##2 o_pass_tokens;
	endproperty
	property p_network_reconfig_event;
		$rose(o_pass_tokens) |-> ##[0:2] o_network_reconfig_event_req;
	endproperty
	property p_order;
		sta_wr |-> opt_r;
	endproperty
	property p_unique;
		cfg_wr && wdata[`NJD_CFG_JOIN] |-> chk_r;
	endproperty
	property p_drop;
		$fell(o_pass_tokens) |-> $past(cfg_wr, 2);
	endproperty
	a_ram: assert property (p_ram)
		else $error("station not stored to RAM");
	a_idle: assert property (p_idle)
		else $error("activity with zero station");
	a_wake: assert property (p_wake)
		else $error("core not woken or joined early");
	a_join: assert property (p_join)
		else $error("join enable ignored");
	a_network_reconfig_event: assert property (p_network_reconfig_event)
		else $error("no reconfiguration on join");
	a_order: assert property (p_order)
		else $error("station written before options");
	a_unique: assert property (p_unique)
		else $error("join before uniqueness check");
	a_drop: assert property (p_drop)
		else $error("token passing stopped unasked");
endmodule
`default_nettype wire

// *** tb/test_node_join_and_network_diagnostics.sv ***
/*
 Bench of the node pair: APB orders to the controller, network events
 to the device. Assumes both ends share one clock.
*/
`include "njd_params.svh"
`default_nettype none
module test_node_join_and_network_diagnostics;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, busy;
	logic joined, rx, tok, ans, trt, nak, core_run, pass_tok, network_reconfig_event, irq;
	logic tx_free, ram_we, ce, tme, txs;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] did, station_number_register, ram_data, sta;
	logic [10:0] ram_addr;
	logic [15:0] rnd = 16'h50f6;
	int error_cnt = 0;
	int total_checks = 0;
	njd_hbus_if i_njd_hbus_if();
	njd_host_init #(.WAIT_CYC(30), .POLL_CYC(20)) i_njd_host_init (
		.i_ref_clk(ref_clk), .i_resetn(resetn), .i_ce(ce),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_busy(busy),
		.o_joined(joined), .bus(i_njd_hbus_if));
	njd_node_diag #(.TWIN_CYC(20), .TWIN_LONG_CYC(40)) i_njd_node_diag (
		.i_ref_clk(ref_clk), .i_resetn(resetn), .i_ce(ce),
		.bus(i_njd_hbus_if), .i_rx_line(rx), .i_tok_seen(tok),
		.i_tok_did(did), .i_tok_own(1'b0), .i_tok_answered(ans),
		.i_tok_to_me(tme), .i_trt_expired(trt), .i_nak(nak),
		.i_tx_start(txs), .i_next_id(station_number_register), .o_core_run(core_run),
		.o_pass_tokens(pass_tok), .o_network_reconfig_event_req(network_reconfig_event),
		.o_refusal_irq(irq), .o_tx_free(tx_free), .o_ram_we(ram_we),
		.o_ram_addr(ram_addr), .o_ram_data(ram_data));
	njd_pair_chk i_njd_pair_chk (.i_ref_clk(ref_clk), .i_resetn(resetn),
		.cs(i_njd_hbus_if.cs), .we(i_njd_hbus_if.we),
		.rd(i_njd_hbus_if.rd), .addr(i_njd_hbus_if.addr),
		.wdata(i_njd_hbus_if.wdata), .o_core_run(core_run),
		.o_pass_tokens(pass_tok), .o_network_reconfig_event_req(network_reconfig_event),
		.o_ram_we(ram_we), .o_ram_addr(ram_addr), .o_ram_data(ram_data));
	// ************
	// Helpers
	// ************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int nak_lim(input logic short_sel);
		return short_sel ? 4 : 128;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic boot(input logic [7:0] o);
		logic e;
		rnd = lfsr(rnd);
		sta = {1'b0, rnd[6:1], 1'b1};
		resetn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		apb(1'b1, `NJD_P_CTRL, {8'h00, sta, o, 8'h01}, e);
		repeat (16) @(posedge ref_clk);
	endtask
	task automatic tok_ev(input logic [7:0] d, input logic a);
		tok <= 1'b1;
		did <= d;
		@(posedge ref_clk);
		tok <= 1'b0;
		ans <= a;
		@(posedge ref_clk);
		ans <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wait_join();
		int n;
		n = 0;
		while (joined !== 1'b1 && n < 600) begin
			@(posedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
		chk(joined, 1'b1);
	endtask
	// ************
	// Stimulus
	// ************
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		logic e;
		{resetn, psel, penable, pwrite, rx, tok, ans, trt, nak} = '0;
		{tme, txs} = 2'b00;
		ce = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		did = 8'h00;
		station_number_register = 8'h00;
		for (int k = 0; k < 2; k++) begin
			boot({5'h00, k[0], k[0], k[0]});
			tok_ev(sta, 1'b1);
			wait_join();
			apb(1'b0, `NJD_P_STAT, 32'h0, e);
			chk(q[15:8], sta + 8'h01);
			for (int i = 1; i <= nak_lim(k[0]); i++) begin
				nak <= 1'b1;
				@(posedge ref_clk);
				nak <= 1'b0;
				@(posedge ref_clk);
				if (i >= nak_lim(k[0]) - 1) begin
					chk(irq, i == nak_lim(k[0]));
				end
			end
		end
		boot(8'h00);
		rnd = lfsr(rnd);
		station_number_register <= rnd[7:0] | 8'h01;
		rx <= 1'b1;
		tok_ev(sta ^ 8'h80, 1'b0);
		rx <= 1'b0;
		wait_join();
		chk(pass_tok, 1'b1);
		apb(1'b0, `NJD_P_STAT, 32'h0, e);
		chk(q[15:8], sta);
		chk(q[23:16] & 8'h4f, 8'h4c);
		apb(1'b0, 12'h008, 32'h0, e);
		chk(e, 1'b1);
		ce <= 1'b0;
		repeat (5) @(posedge ref_clk);
		ce <= 1'b1;
		repeat (45) @(posedge ref_clk);
		apb(1'b0, `NJD_P_STAT, 32'h0, e);
		chk(q[23:16] & 8'h0e, 8'h00);
		for (int i = 0; i < 16; i++) begin
			trt <= 1'b1;
			@(posedge ref_clk);
			trt <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
		apb(1'b0, `NJD_P_STAT, 32'h0, e);
		chk(q[2], 1'b1);
		chk(pass_tok, 1'b0);
		{tme, txs} <= 2'b11;
		@(posedge ref_clk);
		{tme, txs} <= 2'b00;
		repeat (2) @(posedge ref_clk);
		chk(tx_free, 1'b0);
		chk(busy, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
